// file: omm_mapper.sv
`timescale 1ns/1ns
`include "omm_map.svh"
module omm_mapper
#(
	parameter int CPU_HZ   = 16000000,
	parameter int NUM_SEGS = `OMM_MAX_SEGS
)
(
	input  wire logic              clk,
	input  wire logic              resetn,
	// Run control
	input  wire logic              run_req,
	input  wire logic              stop_req,
	input  wire logic              brk_hit,
	input  wire logic              brk_enable,
	input  wire logic              force_special,
	input  wire logic              special_ack,
	output logic                   special_irq,
	output omm_pkg::omm_mode_t     mode,
	output omm_pkg::omm_cause_t    halt_cause,
	// Configuration
	input  wire logic              cfg_we,
	input  wire logic [9:0]        cfg_seg,
	input  wire omm_pkg::omm_attr_t cfg_attr,
	input  wire logic [3:0]        cfg_waits,
	input  wire logic              cfg_waits_en,
	input  wire logic              cfg_waits_we,
	input  wire logic              cfg_high_speed,
	input  wire logic [2:0]        cfg_size,
	input  wire logic              cfg_int_clk,
	output logic                   cfg_rejected,
	output logic                   null_target,
	output logic                   cpu_clk_en,
	// Processor bus
	input  wire omm_pkg::omm_req_t cpu_req,
	output logic                   cpu_ready,
	output logic [15:0]            cpu_rdata,
	// Target bus
	output omm_pkg::omm_req_t      tgt_req,
	input  wire logic              tgt_ready,
	input  wire logic [15:0]       tgt_rdata,
	// Overlay RAM
	output omm_pkg::omm_req_t      ovl_req,
	input  wire logic [15:0]       ovl_rdata
);
	import omm_pkg::*;

	localparam int SPEED_WAIT = (CPU_HZ > `OMM_STD_MAX_HZ) ? 1 : 0;

	omm_attr_t  map_reg [NUM_SEGS];
	logic [3:0] waits_reg;
	logic       waits_en_reg;
	omm_mode_t  mode_reg;
	omm_cause_t cause_reg;
	logic       special_reg;
	logic       stop_pend_reg;
	logic       ovl_busy_reg;
	logic       viol_reg;
	logic       viol_write_reg;
	logic       wc_start;
	logic       wc_busy;
	logic       wc_done;
	logic [4:0] wc_waits;
	logic [9:0] seg_idx;
	omm_attr_t  attr;
	logic       in_cap;
	logic       viol;
	logic       to_ovl;

	////////////////////////////////////////////////////////////////////////
	// Decoding

	// Number of segments populated for a given board size code
	function automatic logic [10:0] seg_limit(input logic [2:0] sz);
		logic [2:0] s;
		s = (sz > `OMM_SIZE_2M) ? `OMM_SIZE_2M : sz;
		seg_limit = 11'(`OMM_SEGS_128K) << s;
	endfunction

	// Segment index of an address
	function automatic logic [9:0] seg_of(input logic [20:0] a);
		seg_of = a[20:`OMM_SEG_LSB];
	endfunction

	assign seg_idx = seg_of(cpu_req.addr);
	assign in_cap  = ({1'b0, seg_idx} < seg_limit(cfg_size));
	// Segments beyond the populated overlay fall back to target
	assign attr    = in_cap ? map_reg[seg_idx] : OMM_ATTR_TARGET;
	assign viol    = (attr == OMM_ATTR_ILLEGAL) ||
	                 (attr == OMM_ATTR_RO && cpu_req.write);
	assign to_ovl  = (attr == OMM_ATTR_RW) || (attr == OMM_ATTR_RO);

	////////////////////////////////////////////////////////////////////////
	// Segment map and wait count, written only in pause

	// Refusing writes while running keeps the map coherent mid-program
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < NUM_SEGS; i++)
				map_reg[i] <= omm_attr_t'(`OMM_ATTR_RST);
		end
		else if (cfg_we && mode_reg == OMM_PAUSE)
			map_reg[cfg_seg] <= cfg_attr;
	end

	// Wait state count and its enable
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			waits_reg    <= `OMM_WAIT_RST;
			waits_en_reg <= 1'b0;
		end
		else if (cfg_waits_we && mode_reg == OMM_PAUSE)
		begin
			waits_reg    <= cfg_waits;
			waits_en_reg <= cfg_waits_en;
		end
	end

	assign cfg_rejected = (cfg_we || cfg_waits_we) && mode_reg == OMM_RUN;

	////////////////////////////////////////////////////////////////////////
	// Bus steering

	// Wait count: programmed waits plus one speed wait on standard board when CPU_HZ is above OMM_STD_MAX_HZ
	assign wc_waits = (waits_en_reg ? {1'b0, waits_reg} : 5'h00) +
	                  ((!cfg_high_speed) ? 5'(SPEED_WAIT) : 5'h00);
	assign wc_start = cpu_req.valid && to_ovl && !viol && !ovl_busy_reg &&
	                  mode_reg == OMM_RUN;

	omm_wait_counter u_wait
	(
		.clk    (clk),
		.resetn (resetn),
		.start  (wc_start),
		.waits  (wc_waits),
		.busy   (wc_busy),
		.done   (wc_done)
	);

	// Marks an overlay access in flight so it is not restarted
	always_ff @(posedge clk)
	begin
		if (!resetn)
			ovl_busy_reg <= 1'b0;
		else if (wc_start && wc_waits != 5'h00)
			ovl_busy_reg <= 1'b1;
		else if (wc_done || !wc_busy)
			ovl_busy_reg <= 1'b0;                                      // Free on the last wait so back to back is not delayed
	end

	// Target segments pass unchanged; overlay segments never reach target
	always_comb
	begin
		tgt_req       = cpu_req;
		tgt_req.valid = cpu_req.valid && !to_ovl && !viol;
		ovl_req       = cpu_req;
		ovl_req.valid = cpu_req.valid && to_ovl && !viol;
	end

	// Target ready passes straight through, adding no waits; in null target mode ready is 1 for target cycles, overlay cycles still wait
	assign cpu_ready = !cpu_req.valid ? 1'b1 :
	                   viol ? 1'b1 :
	                   to_ovl ? ((wc_start && wc_waits == 5'h00) || (ovl_busy_reg && wc_done)) :
	                   (null_target ? 1'b1 : tgt_ready);

	// Read data captured from the serving side
	always_ff @(posedge clk)
	begin
		if (!resetn)
			cpu_rdata <= 16'h0000;
		else if (cpu_req.valid && !cpu_req.write)
			cpu_rdata <= to_ovl ? ovl_rdata : tgt_rdata;
	end

	////////////////////////////////////////////////////////////////////////
	// Violations

	// One-cycle latch of a violation for the run control
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			viol_reg       <= 1'b0;
			viol_write_reg <= 1'b0;
		end
		else
		begin
			viol_reg       <= cpu_req.valid && viol && mode_reg == OMM_RUN;
			viol_write_reg <= cpu_req.valid && cpu_req.write && attr == OMM_ATTR_RO;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Special interrupt before stop

	// Interrupt held until the processor acknowledges, then the stop follows
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			special_reg   <= 1'b0;
			stop_pend_reg <= 1'b0;
		end
		else if (mode_reg == OMM_RUN && force_special && !special_reg)
		begin
			special_reg   <= 1'b1;
			stop_pend_reg <= 1'b1;
		end
		else if (special_reg && special_ack)
			special_reg   <= 1'b0;
		else if (mode_reg == OMM_PAUSE)
			stop_pend_reg <= 1'b0;
	end

	assign special_irq = special_reg;

	////////////////////////////////////////////////////////////////////////
	// Run control

	// Single state register makes run and pause mutually exclusive
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			mode_reg  <= OMM_PAUSE;
			cause_reg <= '0;
		end
		else
		begin
			unique case (mode_reg)
				OMM_PAUSE:
				begin
					if (run_req)
					begin
						mode_reg  <= OMM_RUN;
						cause_reg <= '0;
					end
				end
				OMM_RUN:
				begin
					if (stop_req || (brk_enable && brk_hit) || viol_reg ||
					    (stop_pend_reg && !special_reg))
					begin
						mode_reg              <= OMM_PAUSE;
						cause_reg.manual      <= stop_req;
						cause_reg.brk         <= brk_enable && brk_hit;
						cause_reg.access_viol <= viol_reg && !viol_write_reg;
						cause_reg.write_viol  <= viol_reg && viol_write_reg;
						cause_reg.special     <= stop_pend_reg && !special_reg;
					end
				end
			endcase
		end
	end

	assign mode       = mode_reg;
	assign halt_cause = cause_reg;

	// Null target: device supplies processor clock enable itself
	assign null_target = cfg_int_clk;
	assign cpu_clk_en  = cfg_int_clk;
endmodule

// file: omm_map.svh
`ifndef OMM_MAP_SVH
`define OMM_MAP_SVH

// Segment size is 2KB, so the segment index starts at address bit 11
`define OMM_SEG_LSB        11
// Largest overlay board, 2MB, gives 1024 segments
`define OMM_MAX_SEGS       1024
// Standard overlay memory runs without a wait state up to this clock
`define OMM_STD_MAX_HZ     12000000
// Reset value of the programmable wait state count
`define OMM_WAIT_RST       4'h0
// Reset attribute of every segment: pass to target
`define OMM_ATTR_RST       2'h0
// Overlay size codes: 0=128K 1=256K 2=512K 3=1M 4=2M
`define OMM_SIZE_128K      3'h0
`define OMM_SIZE_2M        3'h4
// Segments covered by the 128K board
`define OMM_SEGS_128K      64

`endif

// file: omm_pkg.sv
package omm_pkg;

	// Segment attribute encoding
	typedef enum logic [1:0]
	{
		OMM_ATTR_TARGET  = 2'h0,
		OMM_ATTR_RW      = 2'h1,
		OMM_ATTR_RO      = 2'h2,
		OMM_ATTR_ILLEGAL = 2'h3
	} omm_attr_t;

	// Run control state
	typedef enum logic
	{
		OMM_PAUSE,
		OMM_RUN
	} omm_mode_t;

	// Processor bus request
	typedef struct packed
	{
		logic        valid;
		logic        write;
		logic [20:0] addr;
		logic [15:0] wdata;
	} omm_req_t;

	// Halt cause bits
	typedef struct packed
	{
		logic manual;
		logic brk;
		logic access_viol;
		logic write_viol;
		logic special;
	} omm_cause_t;

endpackage

// file: omm_wait_counter.sv
`timescale 1ns/1ns
// Counts wait states for one overlay access; done is high in the last wait, while the count is one
module omm_wait_counter
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       start,
	input  wire logic [4:0] waits,
	output logic            busy,
	output logic            done
);
	logic [4:0] cnt_reg;

	// Load on start, count down while busy
	always_ff @(posedge clk)
	begin
		if (!resetn)
			cnt_reg <= 5'h00;
		else if (start)
			cnt_reg <= waits;
		else if (cnt_reg != 5'h00)
			cnt_reg <= cnt_reg - 5'h01;
	end

	assign busy = (cnt_reg != 5'h00);
	assign done = (cnt_reg == 5'h01);
endmodule

// file: omm_chk.sv
`timescale 1ns/1ns
////////////////////////////////////////
// Port checks of run control and bus steering
module omm_chk
(
	input wire logic               clk,
	input wire logic               resetn,
	input wire logic               stop_req,
	input wire logic               brk_hit,
	input wire logic               brk_enable,
	input wire omm_pkg::omm_mode_t  mode,
	input wire omm_pkg::omm_cause_t halt_cause,
	input wire logic               cfg_we,
	input wire logic               cfg_rejected,
	input wire logic               cfg_int_clk,
	input wire logic               null_target,
	input wire logic               cpu_clk_en,
	input wire omm_pkg::omm_req_t  cpu_req,
	input wire logic               cpu_ready,
	input wire omm_pkg::omm_req_t  tgt_req,
	input wire logic               tgt_ready,
	input wire omm_pkg::omm_req_t  ovl_req
);
	import omm_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// A stop cause must land in pause within two edges
	sequence s_to_pause;
		##[1:2] mode == OMM_PAUSE;
	endsequence
	property p_tgt; cpu_req.valid && tgt_req.valid |-> cpu_ready == tgt_ready; endproperty
	a_tgt: assert property (p_tgt) else $error("target ready not passed");
	property p_excl; !(tgt_req.valid && ovl_req.valid); endproperty
	a_excl: assert property (p_excl) else $error("both buses selected");
	property p_gate; tgt_req.valid |-> cpu_req.valid; endproperty
	a_gate: assert property (p_gate) else $error("target cycle without request");
	property p_rej; cfg_we && mode == OMM_RUN |-> cfg_rejected; endproperty
	a_rej: assert property (p_rej) else $error("run config not refused");
	property p_null; null_target == cfg_int_clk && cpu_clk_en == cfg_int_clk; endproperty
	a_null: assert property (p_null) else $error("null target mode wrong");
	property p_stop; mode == OMM_RUN && stop_req |-> s_to_pause; endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");
	property p_brk; mode == OMM_RUN && brk_hit && brk_enable |-> s_to_pause ##0 halt_cause.brk; endproperty
	a_brk: assert property (p_brk) else $error("breakpoint ignored");
	property p_clr; $rose(mode == OMM_RUN) |-> halt_cause == '0; endproperty
	a_clr: assert property (p_clr) else $error("cause kept on run");
endmodule
bind omm_mapper omm_chk omm_chk_inst (.*);

// file: omm_partner.sv
`timescale 1ns/1ns
////////////////////////////////////////
// Target memory with stalls, overlay RAM with fixed data
module omm_partner
(
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire omm_pkg::omm_req_t tgt_req,
	input  wire omm_pkg::omm_req_t ovl_req,
	input  wire logic [1:0]        tgt_lat,
	output logic                   tgt_ready,
	output logic [15:0]            tgt_rdata,
	output logic [15:0]            ovl_rdata,
	output int                     n_tgt
);
	import omm_pkg::*;
	logic [1:0] cnt_reg;
	logic       tog_reg;
	// Idle data toggles so a stale value never passes
	assign tgt_ready = tgt_req.valid && cnt_reg == tgt_lat;
	assign tgt_rdata = tgt_ready ? tgt_req.addr[15:0] ^ 16'hA5A5 : {16{tog_reg}};
	assign ovl_rdata = ovl_req.valid ? ovl_req.addr[15:0] ^ 16'h5A5A : {16{~tog_reg}};
	// Stall count and serviced target cycles
	always_ff @(posedge clk)
	begin
		tog_reg <= resetn & ~tog_reg;
		cnt_reg <= (!resetn || !tgt_req.valid || tgt_ready) ? 2'h0 : cnt_reg + 2'h1;
		n_tgt   <= !resetn ? 0 : n_tgt + int'(tgt_ready);
	end
endmodule

// file: tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %0t %h %h", $time, g, e); end end
module tb_top;
	import omm_pkg::*;
	logic clk = 0, resetn = 0, run_req = 0, stop_req = 0, brk_hit = 0, brk_enable = 0;
	logic force_special = 0, special_ack = 0, cfg_we = 0, cfg_waits_en = 0, cfg_waits_we = 0;
	logic cfg_high_speed = 0, cfg_int_clk = 0, tgt_ready, special_irq, cfg_rejected, null_target, cpu_clk_en, cpu_ready;
	logic [9:0] cfg_seg = 0;
	logic [3:0] cfg_waits = 0;
	logic [2:0] cfg_size = 3'h4;
	logic [1:0] tgt_lat = 0;
	logic [15:0] cpu_rdata, tgt_rdata, ovl_rdata;
	omm_attr_t cfg_attr = OMM_ATTR_TARGET;
	omm_mode_t mode;
	omm_cause_t halt_cause;
	omm_req_t cpu_req = '0, tgt_req, ovl_req;
	int n_mismatch = 0, compares = 0, seed = 94217, cyc = 0, n_tgt, e_tgt = 0, pw = 0, pen = 0;
	int attr_m[1024];
	int sl[4] = '{0, 1, 2, 65};
	omm_mapper omm_mapper_inst (.*);
	omm_partner omm_partner_inst (.*);
	////////////////////////////////////////
	// 100 MHz clock and hang guard
	initial forever #5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tick(int k);
		repeat (k) @(negedge clk);
	endtask
	// Map write, model updated on every call whatever the mode
	task automatic seg(int sg, int at);
		cfg_seg = 10'(sg);
		cfg_attr = omm_attr_t'(at);
		cfg_we = 1;
		tick(1);
		cfg_we = 0;
		attr_m[sg] = at;
		tick(1);
	endtask
	task automatic go();
		run_req = 1;
		tick(1);
		run_req = 0;
		tick(1);
		`CHK(mode, OMM_RUN)
		`CHK(halt_cause, 5'h00)
	endtask
	// Stops itself only for manual cause; other causes are already raised
	task automatic halt(logic [4:0] c);
		stop_req = c == 5'h10;
		tick(1);
		stop_req = 0;
		brk_hit = 0;
		brk_enable = 0;
		tick(2);
		`CHK(mode, OMM_PAUSE)
		`CHK(halt_cause, c)
	endtask
	// One access held until ready; waits and data predicted from the map model
	task automatic acc(bit wr, int sg);
		int s, n, vio, tg;
		logic [20:0] a;
		a = {10'(sg), 11'($random(seed))};
		s = attr_m[sg];
		tg = s == 0 || sg >= (64 << cfg_size);
		vio = !tg && (s == 3 || (s == 2 && wr));
		cpu_req = {1'b1, wr, a, a[15:0] ^ 16'h0F0F};
		tgt_lat = 2'($random(seed));
		for (n = 0; n < 40; n++)
		begin
			#4;
			if (cpu_ready === 1'b1)
				break;
			tick(1);
		end
		if (!vio)
			`CHK(tg ? tgt_req : ovl_req, cpu_req)
		tick(1);
		cpu_req.valid = 0;
		e_tgt += tg;
		`CHK(n, tg ? int'(tgt_lat) : (vio ? 0 : pw + pen))
		if (!wr && !vio)
			`CHK(cpu_rdata, a[15:0] ^ (tg ? 16'hA5A5 : 16'h5A5A))
		tick(1);
	endtask
	////////////////////////////////////////
	// Main sequence
	initial
	begin
		foreach (attr_m[i]) attr_m[i] = 0;
		tick(8);
		resetn = 1;
		tick(1);
		`CHK(mode, OMM_PAUSE)
		for (int i = 1; i < 4; i++) seg(i, i);
		seg(65, 1);
		for (int k = 0; k < 4; k++)
		begin
			cfg_waits = k == 3 ? 4'hF : 4'($random(seed));
			cfg_waits_en = k != 0;
			cfg_high_speed = k[0];
			cfg_size = k == 2 ? 3'h0 : 3'h4;
			cfg_waits_we = 1;
			tick(1);
			cfg_waits_we = 0;
			pw = k != 0 ? int'(cfg_waits) : 0;
			pen = !cfg_high_speed;
			go();
			for (int j = 0; j < 12; j++) acc(j > 3 && sl[j % 4] != 2 && $random(seed) % 2 != 0, sl[j % 4]);
			halt(5'h10);
			$display("test config %0d done", k);
		end
		`CHK(n_tgt, e_tgt)
		go();
		acc(1, 2);
		halt(5'h02);
		go();
		acc(0, 3);
		halt(5'h04);
		go();
		brk_hit = 1;
		tick(3);
		`CHK(mode, OMM_RUN)
		brk_enable = 1;
		halt(5'h08);
		go();
		force_special = 1;
		tick(1);
		force_special = 0;
		tick(3);
		`CHK({special_irq, mode}, {1'b1, OMM_RUN})
		special_ack = 1;
		halt(5'h01);
		special_ack = 0;
		`CHK(special_irq, 1'b0)
		go();
		cfg_seg = 10'h001;
		cfg_attr = OMM_ATTR_TARGET;
		cfg_we = 1;
		#1 `CHK(cfg_rejected, 1'b1)
		tick(1);
		cfg_we = 0;
		acc(0, 1);
		halt(5'h10);
		cfg_int_clk = 1;
		#1 `CHK({null_target, cpu_clk_en}, 2'h3)
		$display("test controls done");
		report_and_stop();
	end
endmodule
